//--- lec_eq_if.sv
// Carries one equalizer bank's write port and read/apply data between the top and the bank store
interface lec_eq_if;
  logic      wr_en;
  logic      wr_port;
  logic      wr_floor;
  logic [7:0] wr_data;
  logic      rd_port;
  logic [7:0] byp_q;
  logic [7:0] flr_q;
  logic [7:0] byp0_q;
  logic [7:0] flr0_q;
  logic [7:0] byp1_q;
  logic [7:0] flr1_q;
  modport host (output wr_en, wr_port, wr_floor, wr_data, rd_port,
                input byp_q, flr_q, byp0_q, flr0_q, byp1_q, flr1_q);
  modport store (input wr_en, wr_port, wr_floor, wr_data, rd_port,
                 output byp_q, flr_q, byp0_q, flr0_q, byp1_q, flr1_q);
endinterface

//--- lec_eq_store.sv
// Per-port equalizer bypass and floor register store
`include "lec_map.svh"
module lec_eq_store (
  input  wire logic clk,
  input  wire logic rst,
  lec_eq_if.store   eq
);
  import lec_pkg::*;
  logic [7:0] byp_q [`LEC_PORTS];
  logic [7:0] flr_q [`LEC_PORTS];
  logic [7:0] rbyp_q;
  logic [7:0] rflr_q;

  // Writes land in the bank picked by the second-port select [R10]
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      for (int i = 0; i < `LEC_PORTS; i++) begin
        byp_q[i] <= `LEC_RST_EQ_BYPASS;
        flr_q[i] <= `LEC_RST_EQ_FLOOR;
      end
    end else if (eq.wr_en) begin
      if (eq.wr_floor) flr_q[eq.wr_port] <= eq.wr_data;
      else byp_q[eq.wr_port] <= eq.wr_data;
    end
  end

  // Read data comes out of a register, one cycle after the port select is seen
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      rbyp_q <= `LEC_RST_EQ_BYPASS;
      rflr_q <= `LEC_RST_EQ_FLOOR;
    end else begin
      rbyp_q <= byp_q[eq.rd_port];
      rflr_q <= flr_q[eq.rd_port];
    end
  end

  assign eq.byp_q  = rbyp_q;
  assign eq.flr_q  = rflr_q;
  assign eq.byp0_q = byp_q[0];
  assign eq.flr0_q = flr_q[0];
  assign eq.byp1_q = byp_q[1];
  assign eq.flr1_q = flr_q[1];
endmodule

//--- lec_map.svh
// Register offsets, field positions, reset values and response codes of the link/control/equalizer bank
`ifndef LEC_MAP_SVH
`define LEC_MAP_SVH
`define LEC_IDX_LINK_ERR      8'h41
`define LEC_IDX_BCH_MODE      8'h43
`define LEC_IDX_EQ_BYPASS     8'h44
`define LEC_IDX_EQ_FLOOR      8'h45
`define LEC_IDX_IRQ_STATUS    8'h48
`define LEC_IDX_IRQ_MASK      8'h49
`define LEC_IDX_PORT_CTRL     8'h4A
`define LEC_IDX_LINK_STATUS   8'h4B
`define LEC_RST_LINK_ERR      8'h03
`define LEC_RST_BCH_MODE      8'h00
`define LEC_RST_EQ_BYPASS     8'h60
`define LEC_RST_EQ_FLOOR      8'h80
`define LEC_RST_ZERO8         8'h00
`define LEC_ERR_EN_BIT        4
`define LEC_ERR_THR_HI        3
`define LEC_ERR_THR_LO        0
`define LEC_MISO_MODE_BIT     4
`define LEC_CPOL_BIT          3
`define LEC_MODE_HI           2
`define LEC_MODE_LO           0
`define LEC_EQ_UP_HI          7
`define LEC_EQ_UP_LO          5
`define LEC_EQ_LO_HI          3
`define LEC_EQ_LO_LO          1
`define LEC_EQ_BYP_BIT        0
`define LEC_FLOOR_HI          3
`define LEC_FLOOR_LO          0
`define LEC_PORT_SEL_BIT      0
`define LEC_FLOOR_EN_BIT      1
`define LEC_IRQ_LOCK_LOST     0
`define LEC_IRQ_LINK_ERR      1
`define LEC_IRQ_BAD_MODE      2
`define LEC_IRQ_W             3
`define LEC_RESP_OKAY         2'h0
`define LEC_RESP_SLVERR       2'h2
`define LEC_PORTS             2
`define LEC_ADDR_IDX_HI       9
`define LEC_ADDR_IDX_LO       2
`endif

//--- lec_pkg.sv
// Types shared by the link/control/equalizer register bank
package lec_pkg;
  typedef enum logic [2:0] {
    LEC_MODE_NORMAL_GPIO = 3'h0,
    LEC_MODE_HS_GPIO1    = 3'h1,
    LEC_MODE_HS_GPIO2    = 3'h2,
    LEC_MODE_HS_GPIO4    = 3'h3,
    LEC_MODE_RSVD4       = 3'h4,
    LEC_MODE_RSVD5       = 3'h5,
    LEC_MODE_FWD_SPI     = 3'h6,
    LEC_MODE_REV_SPI     = 3'h7
  } lec_bch_mode_t;
  typedef enum logic {LEC_LOCKED, LEC_UNLOCKED} lec_lock_st_t;
  typedef logic [7:0] lec_byte_t;
  typedef logic [5:0] lec_eq_set_t;
endpackage

//--- lec_regs.sv
// Link error threshold, back-channel mode and equalizer control registers behind an AXI4-Lite slave
// Summary of operation
// R1: Count link errors only while enable set
// R2: Drop lock when count reaches threshold
// R3: Pixel-clock counter watches clocks and alignment
// R4: Counting disabled: first error drops lock
// R5: Reverse SPI: MISO always driven or SS-gated
// R6: Polarity bit swaps SPI drive/sample edges
// R7: Three-bit field selects back-channel mode
// R8: Bypass bit disables adaptive equalization
// R9: Bypass applies fixed six-bit equalizer setting
// R10: Port select steers equalizer writes
// R11: Floor enable starts adaptation at floor
// R12: Floor start instead of zero start
// R13: Reserved bits keep written values, no effect; the IRQ mask keeps only bits 2:0
//
// Chosen here: register access over AXI4-Lite.
`include "lec_map.svh"
module lec_regs (
  input  wire logic                 clk,
  input  wire logic                 rst,
  input  wire logic [9:0]           s_axi_awaddr,
  input  wire logic                 s_axi_awvalid,
  output logic                      s_axi_awready,
  input  wire logic [31:0]          s_axi_wdata,
  input  wire logic [3:0]           s_axi_wstrb,
  input  wire logic                 s_axi_wvalid,
  output logic                      s_axi_wready,
  output logic [1:0]                s_axi_bresp,
  output logic                      s_axi_bvalid,
  input  wire logic                 s_axi_bready,
  input  wire logic [9:0]           s_axi_araddr,
  input  wire logic                 s_axi_arvalid,
  output logic                      s_axi_arready,
  output logic [31:0]               s_axi_rdata,
  output logic [1:0]                s_axi_rresp,
  output logic                      s_axi_rvalid,
  input  wire logic                 s_axi_rready,
  input  wire logic                 pix_en,
  input  wire logic                 clk0_err,
  input  wire logic                 clk1_err,
  input  wire logic                 link_alignment_err,
  input  wire logic                 lock_restart,
  input  wire logic                 floor_pin,
  input  wire logic                 spi_ss_n,
  input  wire logic                 spi_miso_data,
  output logic                      link_locked,
  output logic                      spi_miso_o,
  output logic                      spi_miso_oe,
  output logic                      spi_drive_on_rise,
  output lec_pkg::lec_bch_mode_t    fast_ctrl_channel_mode,
  output logic [3:0]                hs_gpio_count,
  output logic                      spi_fwd_mode,
  output logic                      spi_rev_mode,
  output logic                      port0_adapt_en,
  output lec_pkg::lec_eq_set_t      port0_eq_fixed,
  output logic [3:0]                port0_eq_start,
  output logic                      port1_adapt_en,
  output lec_pkg::lec_eq_set_t      port1_eq_fixed,
  output logic [3:0]                port1_eq_start,
  output logic                      irq
);
  import lec_pkg::*;

  lec_eq_if eq ();
  lec_eq_store u_store (
    .clk (clk),
    .rst (rst),
    .eq  (eq)
  );

  // One register per word: the index is the byte address over four, so the bus needs ten address bits
  function automatic logic [7:0] idx_of(input logic [9:0] addr);
    return addr[`LEC_ADDR_IDX_HI:`LEC_ADDR_IDX_LO];
  endfunction

  function automatic lec_eq_set_t eq_fixed(input logic [7:0] r);
    return {r[`LEC_EQ_UP_HI:`LEC_EQ_UP_LO], r[`LEC_EQ_LO_HI:`LEC_EQ_LO_LO]};
  endfunction

  lec_byte_t    err_q, mode_q, port_q;
  logic [2:0]   st_q, mask_q;
  logic [3:0]   cnt_q;
  lec_lock_st_t lock_q;
  logic         aw_q, w_q;
  logic [7:0]   awidx_q;
  logic [31:0]  wdat_q;
  logic [3:0]   wstb_q;
  logic         rd_pend_q;
  logic [7:0]   rdidx_q;
  logic         any_err, cnt_en, lock_drop, bad_mode;
  logic         wr_fire;
  logic [2:0]   ev;

  // Write channel: address and data taken in either order, response after both
  assign wr_fire = aw_q && w_q && !s_axi_bvalid;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      aw_q          <= 1'b0;
      w_q           <= 1'b0;
      awidx_q       <= `LEC_RST_ZERO8;
      wdat_q        <= '0;
      wstb_q        <= '0;
      s_axi_awready <= 1'b0;
      s_axi_wready  <= 1'b0;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= `LEC_RESP_OKAY;
    end else begin
      s_axi_awready <= !aw_q && !s_axi_awready && s_axi_awvalid && !s_axi_bvalid;
      s_axi_wready  <= !w_q && !s_axi_wready && s_axi_wvalid && !s_axi_bvalid;
      if (s_axi_awvalid && s_axi_awready) begin
        aw_q    <= 1'b1;
        awidx_q <= idx_of(s_axi_awaddr);
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_q    <= 1'b1;
        wdat_q <= s_axi_wdata;
        wstb_q <= s_axi_wstrb;
      end
      if (wr_fire) begin
        aw_q         <= 1'b0;
        w_q          <= 1'b0;
        s_axi_bvalid <= 1'b1;
        unique case (awidx_q)
          `LEC_IDX_LINK_ERR, `LEC_IDX_BCH_MODE, `LEC_IDX_EQ_BYPASS, `LEC_IDX_EQ_FLOOR,
          `LEC_IDX_IRQ_STATUS, `LEC_IDX_IRQ_MASK, `LEC_IDX_PORT_CTRL,
          `LEC_IDX_LINK_STATUS: s_axi_bresp <= `LEC_RESP_OKAY;
          default: s_axi_bresp <= `LEC_RESP_SLVERR;
        endcase
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // Plain control registers; reserved bits are stored as written and drive nothing, except in the IRQ mask, which keeps only bits 2:0 [R13]
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      err_q  <= `LEC_RST_LINK_ERR;
      mode_q <= `LEC_RST_BCH_MODE;
      port_q <= `LEC_RST_ZERO8;
      mask_q <= '0;
    end else if (wr_fire && wstb_q[0]) begin
      if (awidx_q == `LEC_IDX_LINK_ERR) err_q <= wdat_q[7:0];
      if (awidx_q == `LEC_IDX_BCH_MODE) mode_q <= wdat_q[7:0];
      if (awidx_q == `LEC_IDX_PORT_CTRL) port_q <= wdat_q[7:0];
      if (awidx_q == `LEC_IDX_IRQ_MASK) mask_q <= wdat_q[`LEC_IRQ_W-1:0];
    end
  end

  // Equalizer writes go to the bank the port select names [R10]
  always_comb begin
    eq.wr_en    = wr_fire && wstb_q[0] &&
                  (awidx_q == `LEC_IDX_EQ_BYPASS || awidx_q == `LEC_IDX_EQ_FLOOR);
    eq.wr_floor = (awidx_q == `LEC_IDX_EQ_FLOOR);
    eq.wr_port  = port_q[`LEC_PORT_SEL_BIT];
    eq.wr_data  = wdat_q[7:0];
    eq.rd_port  = port_q[`LEC_PORT_SEL_BIT];
  end

  // Error watch over both recovered clocks and the alignment signal, advanced per pixel clock [R3]
  assign any_err = pix_en && (clk0_err || clk1_err || link_alignment_err);
  assign cnt_en  = err_q[`LEC_ERR_EN_BIT];
  // Enabled: drop when count reaches threshold [R2]; disabled: first error drops [R4]
  assign lock_drop = any_err && (!cnt_en ||
                     ({1'b0, cnt_q} + 5'h01 >= {1'b0, err_q[`LEC_ERR_THR_HI:`LEC_ERR_THR_LO]}));

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      cnt_q  <= '0;
      lock_q <= LEC_LOCKED;
    end else begin
      unique case (lock_q)
        LEC_LOCKED: begin
          if (lock_drop) begin
            lock_q <= LEC_UNLOCKED;
            cnt_q  <= '0;
          end else if (any_err && cnt_en) begin
            cnt_q <= cnt_q + 4'h1; // [R1]
          end
        end
        LEC_UNLOCKED: begin
          // A zero threshold is met by any count after a clean restart, so it behaves as one error
          if (lock_restart) lock_q <= LEC_LOCKED;
        end
      endcase
    end
  end

  assign bad_mode = (mode_q[`LEC_MODE_HI:`LEC_MODE_LO] == LEC_MODE_RSVD4) ||
                    (mode_q[`LEC_MODE_HI:`LEC_MODE_LO] == LEC_MODE_RSVD5);
  always_comb begin
    ev = '0;
    ev[`LEC_IRQ_LOCK_LOST] = (lock_q == LEC_LOCKED) && lock_drop;
    ev[`LEC_IRQ_LINK_ERR]  = any_err;
    ev[`LEC_IRQ_BAD_MODE]  = bad_mode;
  end

  // Sticky status, write one to clear; a new event in the clearing cycle wins
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      st_q <= '0;
    end else if (wr_fire && wstb_q[0] && awidx_q == `LEC_IDX_IRQ_STATUS) begin
      st_q <= (st_q & ~wdat_q[`LEC_IRQ_W-1:0]) | ev;
    end else begin
      st_q <= st_q | ev;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) irq <= 1'b0;
    else irq <= |(st_q & mask_q);
  end

  // Read channel: one cycle to capture, one to present through the store's registered data
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= '0;
      s_axi_rresp   <= `LEC_RESP_OKAY;
      rd_pend_q     <= 1'b0;
      rdidx_q       <= `LEC_RST_ZERO8;
    end else begin
      s_axi_arready <= !s_axi_arready && !rd_pend_q && !s_axi_rvalid && s_axi_arvalid;
      if (s_axi_arvalid && s_axi_arready) begin
        rd_pend_q <= 1'b1;
        rdidx_q   <= idx_of(s_axi_araddr);
      end
      if (rd_pend_q) begin
        rd_pend_q    <= 1'b0;
        s_axi_rvalid <= 1'b1;
        s_axi_rresp  <= `LEC_RESP_OKAY;
        s_axi_rdata  <= '0;
        unique case (rdidx_q)
          `LEC_IDX_LINK_ERR:    s_axi_rdata[7:0] <= err_q;
          `LEC_IDX_BCH_MODE:    s_axi_rdata[7:0] <= mode_q;
          `LEC_IDX_EQ_BYPASS:   s_axi_rdata[7:0] <= eq.byp_q;
          `LEC_IDX_EQ_FLOOR:    s_axi_rdata[7:0] <= eq.flr_q;
          `LEC_IDX_IRQ_STATUS:  s_axi_rdata[`LEC_IRQ_W-1:0] <= st_q;
          `LEC_IDX_IRQ_MASK:    s_axi_rdata[`LEC_IRQ_W-1:0] <= mask_q;
          `LEC_IDX_PORT_CTRL:   s_axi_rdata[7:0] <= port_q;
          `LEC_IDX_LINK_STATUS: s_axi_rdata[7:0] <= {3'h0, lock_q == LEC_LOCKED, cnt_q};
          default:              s_axi_rresp <= `LEC_RESP_SLVERR;
        endcase
      end else if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end

  // Back-channel mode decode [R7]
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      fast_ctrl_channel_mode <= LEC_MODE_NORMAL_GPIO;
      hs_gpio_count          <= '0;
      spi_fwd_mode           <= 1'b0;
      spi_rev_mode           <= 1'b0;
    end else begin
      fast_ctrl_channel_mode <= lec_bch_mode_t'(mode_q[`LEC_MODE_HI:`LEC_MODE_LO]);
      spi_fwd_mode           <= mode_q[`LEC_MODE_HI:`LEC_MODE_LO] == LEC_MODE_FWD_SPI;
      spi_rev_mode           <= mode_q[`LEC_MODE_HI:`LEC_MODE_LO] == LEC_MODE_REV_SPI;
      unique case (lec_bch_mode_t'(mode_q[`LEC_MODE_HI:`LEC_MODE_LO]))
        LEC_MODE_HS_GPIO1: hs_gpio_count <= 4'h1;
        LEC_MODE_HS_GPIO2: hs_gpio_count <= 4'h2;
        LEC_MODE_HS_GPIO4: hs_gpio_count <= 4'h4;
        default:           hs_gpio_count <= 4'h0;
      endcase
    end
  end

  // SPI pin control: MISO enable in reverse SPI [R5], edge choice [R6]
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      spi_miso_o        <= 1'b0;
      spi_miso_oe       <= 1'b0;
      spi_drive_on_rise <= 1'b0;
    end else begin
      spi_miso_o        <= spi_miso_data;
      spi_miso_oe       <= (mode_q[`LEC_MODE_HI:`LEC_MODE_LO] == LEC_MODE_REV_SPI) &&
                           (!mode_q[`LEC_MISO_MODE_BIT] || !spi_ss_n); // [R5]
      spi_drive_on_rise <= mode_q[`LEC_CPOL_BIT]; // [R6]
    end
  end

  // Equalizer controls per port: bypass [R8], fixed setting [R9], floor start [R11] [R12]
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      link_locked    <= 1'b0;
      port0_adapt_en <= 1'b0;
      port0_eq_fixed <= '0;
      port0_eq_start <= '0;
      port1_adapt_en <= 1'b0;
      port1_eq_fixed <= '0;
      port1_eq_start <= '0;
    end else begin
      link_locked    <= (lock_q == LEC_LOCKED);
      port0_adapt_en <= !eq.byp0_q[`LEC_EQ_BYP_BIT]; // [R8]
      port0_eq_fixed <= eq_fixed(eq.byp0_q); // [R9]
      port0_eq_start <= (floor_pin || port_q[`LEC_FLOOR_EN_BIT]) ?
                        eq.flr0_q[`LEC_FLOOR_HI:`LEC_FLOOR_LO] : 4'h0; // [R11] [R12]
      port1_adapt_en <= !eq.byp1_q[`LEC_EQ_BYP_BIT];
      port1_eq_fixed <= eq_fixed(eq.byp1_q);
      port1_eq_start <= (floor_pin || port_q[`LEC_FLOOR_EN_BIT]) ?
                        eq.flr1_q[`LEC_FLOOR_HI:`LEC_FLOOR_LO] : 4'h0;
    end
  end
endmodule

//--- lec_regs_checker.sv
// Port-level assertions for the link, back-channel and equalizer register bank
module lec_regs_checker
  import lec_pkg::*;
(
  input wire logic          clk,
  input wire logic          rst,
  input wire logic [1:0]    s_axi_bresp,
  input wire logic          s_axi_bvalid,
  input wire logic          s_axi_bready,
  input wire logic          s_axi_arvalid,
  input wire logic          s_axi_arready,
  input wire logic          s_axi_rvalid,
  input wire logic          pix_en,
  input wire logic          clk0_err,
  input wire logic          clk1_err,
  input wire logic          link_alignment_err,
  input wire logic          lock_restart,
  input wire logic          link_locked,
  input wire logic          spi_ss_n,
  input wire logic          spi_miso_data,
  input wire logic          spi_miso_o,
  input wire logic          spi_miso_oe,
  input wire lec_bch_mode_t fast_ctrl_channel_mode,
  input wire logic [3:0]    hs_gpio_count,
  input wire logic          spi_fwd_mode,
  input wire logic          spi_rev_mode
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  logic       ev;
  logic [3:0] gc_exp;
  assign ev = pix_en && (clk0_err || clk1_err || link_alignment_err);
  assign gc_exp = (fast_ctrl_channel_mode == LEC_MODE_HS_GPIO4) ? 4'h4 :
                  (fast_ctrl_channel_mode[2] ? 4'h0 : {1'b0, fast_ctrl_channel_mode});
  a_miso_selected: assert property (
    spi_rev_mode && $past(spi_rev_mode) && !spi_ss_n |=> spi_miso_oe || !spi_rev_mode)
    else $error("MISO released while selected");
  a_miso_data: assert property (spi_miso_oe |-> spi_miso_o == $past(spi_miso_data))
    else $error("MISO value does not follow its source");
  a_gpio_count: assert property (hs_gpio_count == gc_exp)
    else $error("GPIO count does not match mode");
  a_spi_decode: assert property (
    spi_fwd_mode == (fast_ctrl_channel_mode == LEC_MODE_FWD_SPI) &&
    spi_rev_mode == (fast_ctrl_channel_mode == LEC_MODE_REV_SPI))
    else $error("SPI mode flags do not match mode");
  a_lock_cause: assert property ($fell(link_locked) |-> $past(ev) || $past(ev, 2))
    else $error("Lock dropped without an error event");
  a_unlock_holds: assert property (!link_locked && !$past(lock_restart) && !$past(rst) |=> !link_locked)
    else $error("Lock regained without restart");
  a_bresp_stand: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("Write response withdrawn early");
  a_read_latency: assert property (s_axi_arvalid && s_axi_arready |-> ##2 s_axi_rvalid)
    else $error("Read data late");
endmodule

//--- lec_ser_model.sv
// Far-end serializer model: pixel enables, link error events, SPI select and MISO data
module lec_ser_model (
  input  wire logic       clk,
  input  wire logic       rst,
  input  wire logic [1:0] err_req,
  input  wire logic       ss_req,
  output logic            pix_en,
  output logic            clk0_err,
  output logic            clk1_err,
  output logic            link_alignment_err,
  output logic            spi_ss_n,
  output logic            spi_miso_data
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [1:0] pend_q;
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      pix_en <= 1'b0;
      spi_miso_data <= 1'b0;
      spi_ss_n <= 1'b1;
    end else begin
      pix_en <= ~pix_en;
      // Toggles every cycle so a stale MISO value never looks right
      spi_miso_data <= ~spi_miso_data;
      spi_ss_n <= ~ss_req;
    end
  end
  // Error line rises only with one pixel enable, so each request is exactly one event
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      pend_q <= 2'h0;
      {clk0_err, clk1_err, link_alignment_err} <= 3'h0;
    end else begin
      if (err_req != 2'h0) pend_q <= err_req;
      else if (!pix_en) pend_q <= 2'h0;
      clk0_err <= !pix_en && pend_q == 2'h1;
      clk1_err <= !pix_en && pend_q == 2'h2;
      link_alignment_err <= !pix_en && pend_q == 2'h3;
    end
  end
endmodule

//--- tb_top.sv
// Self-checking bench for the link, back-channel and equalizer register bank
`include "lec_map.svh"
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  import lec_pkg::*;
  localparam logic [7:0] i_le = `LEC_IDX_LINK_ERR;
  localparam logic [7:0] i_md = `LEC_IDX_BCH_MODE;
  localparam logic [7:0] i_by = `LEC_IDX_EQ_BYPASS;
  localparam logic [7:0] i_fl = `LEC_IDX_EQ_FLOOR;
  logic        clk = 1'b0;
  logic        rst = 1'b1;
  logic [9:0]  s_axi_awaddr = 10'h000;
  logic [9:0]  s_axi_araddr = 10'h000;
  logic [31:0] s_axi_wdata = 32'h0;
  logic [3:0]  s_axi_wstrb = 4'hF;
  logic        s_axi_awvalid = 1'b0;
  logic        s_axi_wvalid = 1'b0;
  logic        s_axi_bready = 1'b0;
  logic        s_axi_arvalid = 1'b0;
  logic        s_axi_rready = 1'b0;
  logic        lock_restart = 1'b0;
  logic        floor_pin = 1'b0;
  logic        ss_req = 1'b0;
  logic [1:0]  err_req = 2'h0;
  logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0]  s_axi_bresp, s_axi_rresp;
  logic [31:0] s_axi_rdata;
  logic        pix_en, clk0_err, clk1_err, link_alignment_err, spi_ss_n, spi_miso_data;
  logic        link_locked, spi_miso_o, spi_miso_oe, spi_drive_on_rise, spi_fwd_mode, spi_rev_mode, irq;
  logic        port0_adapt_en, port1_adapt_en;
  logic [3:0]  hs_gpio_count, port0_eq_start, port1_eq_start;
  lec_eq_set_t port0_eq_fixed, port1_eq_fixed;
  lec_bch_mode_t fast_ctrl_channel_mode;
  int          err_total = 0;
  int          checked = 0;
  always #5 clk = ~clk;
  lec_regs dut (.*);
  lec_ser_model far_end (.*);
  task automatic print_verdict;
    if (err_total == 0 && checked > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      err_total++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic tk(input int c);
    repeat (c) @(posedge clk);
  endtask
  // Byte address is four times the register index
  function automatic logic [9:0] ba(input logic [7:0] idx);
    return {idx, 2'b00};
  endfunction
  task automatic wr(input logic [7:0] idx, input logic [7:0] d, input logic [1:0] er = `LEC_RESP_OKAY);
    int n;
    n = 0;
    s_axi_awaddr <= ba(idx);
    s_axi_wdata <= {24'h0, d};
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    do begin
      @(posedge clk);
      n++;
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (!s_axi_bvalid && n < 64);
    if (n >= 64) begin
      cmp(32'h0, 32'h1);
      print_verdict;
    end
    // Late ready keeps the response waiting for a cycle
    s_axi_bready <= 1'b1;
    @(posedge clk);
    s_axi_bready <= 1'b0;
    cmp(s_axi_bresp, er);
  endtask
  task automatic rd(input logic [7:0] idx, input logic [7:0] ed, input logic [1:0] er = `LEC_RESP_OKAY);
    int n;
    n = 0;
    s_axi_araddr <= ba(idx);
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do begin
      @(posedge clk);
      n++;
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (!s_axi_rvalid && n < 64);
    if (n >= 64) begin
      cmp(32'h0, 32'h1);
      print_verdict;
    end
    // Ready stays up between reads so back-to-back calls never drive it twice in one step
    cmp(s_axi_rdata, {24'h0, ed});
    cmp(s_axi_rresp, er);
  endtask
  task automatic wait_lock(input logic v);
    int n;
    n = 0;
    while (link_locked !== v && n < 8) begin
      @(posedge clk);
      n++;
    end
    cmp(link_locked, v);
    if (link_locked !== v) print_verdict;
  endtask
  task automatic hit(input logic [1:0] s);
    err_req <= s;
    @(posedge clk);
    err_req <= 2'h0;
    tk(4);
  endtask
  task automatic restart;
    lock_restart <= 1'b1;
    @(posedge clk);
    lock_restart <= 1'b0;
    wait_lock(1'b1);
  endtask
  task automatic t_reset;
    rd(i_le, `LEC_RST_LINK_ERR);
    rd(i_md, `LEC_RST_BCH_MODE);
    rd(i_by, `LEC_RST_EQ_BYPASS);
    rd(i_fl, `LEC_RST_EQ_FLOOR);
    cmp(port0_adapt_en, 1'b1);
    cmp(port0_eq_fixed, 6'h18);
    rd(8'h40, 8'h00, `LEC_RESP_SLVERR);
    wr(8'h40, 8'hFF, `LEC_RESP_SLVERR);
  endtask
  task automatic t_nocount;
    for (int s = 1; s < 4; s++) begin
      hit(2'(s));
      wait_lock(1'b0);
      restart;
    end
  endtask
  task automatic t_count;
    wr(i_le, 8'h12);
    hit(2'h1);
    tk(4);
    cmp(link_locked, 1'b1);
    rd(`LEC_IDX_LINK_STATUS, 8'h11);
    hit(2'h3);
    wait_lock(1'b0);
    rd(`LEC_IDX_IRQ_STATUS, 8'h03);
    restart;
    wr(i_le, `LEC_RST_LINK_ERR);
  endtask
  task automatic t_modes;
    logic [3:0] gc [8] = '{4'h0, 4'h1, 4'h2, 4'h4, 4'h0, 4'h0, 4'h0, 4'h0};
    for (int m = 0; m < 8; m++) begin
      wr(i_md, 8'(m));
      tk(2);
      cmp(fast_ctrl_channel_mode, m[2:0]);
      cmp(hs_gpio_count, gc[m]);
      cmp(spi_fwd_mode, m == 6);
      cmp(spi_rev_mode, m == 7);
    end
  endtask
  task automatic t_irq;
    wr(`LEC_IDX_IRQ_STATUS, 8'h07);
    wr(`LEC_IDX_IRQ_MASK, 8'h04);
    wr(i_md, 8'h05);
    tk(3);
    cmp(irq, 1'b1);
    wr(i_md, 8'h00);
    wr(`LEC_IDX_IRQ_STATUS, 8'h04);
    tk(3);
    cmp(irq, 1'b0);
    wr(`LEC_IDX_IRQ_MASK, 8'h00);
    wr(i_md, 8'h04);
    tk(3);
    cmp(irq, 1'b0);
    rd(`LEC_IDX_IRQ_STATUS, 8'h04);
  endtask
  task automatic t_spi;
    wr(i_md, 8'h07);
    tk(3);
    cmp(spi_miso_oe, 1'b1);
    cmp(spi_drive_on_rise, 1'b0);
    wr(i_md, 8'h17);
    tk(3);
    cmp(spi_miso_oe, 1'b0);
    ss_req <= 1'b1;
    tk(3);
    cmp(spi_miso_oe, 1'b1);
    wr(i_md, 8'hFF);
    tk(2);
    cmp(spi_drive_on_rise, 1'b1);
    rd(i_md, 8'hFF);
    ss_req <= 1'b0;
  endtask
  task automatic t_eq;
    wr(i_by, 8'hB7);
    tk(2);
    cmp(port0_adapt_en, 1'b0);
    cmp(port0_eq_fixed, 6'h2B);
    rd(i_by, 8'hB7);
    wr(`LEC_IDX_PORT_CTRL, 8'h01);
    wr(i_by, 8'h0E);
    wr(i_fl, 8'h85);
    tk(2);
    cmp(port1_eq_fixed, 6'h07);
    cmp(port1_adapt_en, 1'b1);
    cmp(port0_eq_fixed, 6'h2B);
    cmp(port1_eq_start, 4'h0);
    rd(i_fl, 8'h85);
    floor_pin <= 1'b1;
    tk(3);
    cmp(port1_eq_start, 4'h5);
    floor_pin <= 1'b0;
    wr(`LEC_IDX_PORT_CTRL, 8'h03);
    tk(2);
    cmp(port1_eq_start, 4'h5);
    cmp(port0_eq_start, 4'h0);
  endtask
  initial begin
    tk(12);
    rst <= 1'b0;
    tk(1);
    t_reset;
    t_nocount;
    t_count;
    t_modes;
    t_irq;
    t_spi;
    t_eq;
    rst <= 1'b1;
    tk(2);
    rst <= 1'b0;
    tk(1);
    rd(i_by, `LEC_RST_EQ_BYPASS);
    print_verdict;
  end
endmodule
bind lec_regs lec_regs_checker chk (.*);
